/* logic/ccp_defs.svh */
`ifndef CCP_DEFS_SVH
`define CCP_DEFS_SVH

// Cache control register layout
`define CCP_CREG_DCE_BIT 31
`define CCP_CREG_ICE_BIT 15
`define CCP_CREG_RESET   32'h0000_0000

// Replacement counter
`define CCP_CTR_W        2
`define CCP_CTR_RESET    2'h0
`define CCP_WAYS         4

// Instruction holding register: words per half-line usable by a loop
`define CCP_HOLD_WORDS   2'h3

`endif

/* logic/ccp_pkg.sv */
package ccp_pkg;

  typedef enum logic [1:0] {
    CCP_MODE_WTHRU  = 2'h0,
    CCP_MODE_CPBACK = 2'h1,
    CCP_MODE_NONSER = 2'h2,
    CCP_MODE_SERIAL = 2'h3
  } ccp_mode_t;

  typedef enum logic [6:0] {
    CCP_ST_IDLE = 7'h01,
    CCP_ST_FILL = 7'h02,
    CCP_ST_WBCK = 7'h04,
    CCP_ST_WTHR = 7'h08,
    CCP_ST_PUSH = 7'h10,
    CCP_ST_INHB = 7'h20,
    CCP_ST_BYPS = 7'h40
  } ccp_state_t;

endpackage : ccp_pkg

/* logic/ccp_cache_policy.sv */
`timescale 1ns/100ps
`include "ccp_defs.svh"

// Notes on behaviour
// - Allocate first invalid way, else counter victim
// - Separate 2-bit replacement counter per cache
// - Instruction counter counts each half-line access
// - Data counter: reads, copyback writes, write-through transfers
// - Full set: replace counter way, then increment
// - Enables at bits 31, 15; no line change
// - Reset clears control register and counters, not lines
// - Disable pin overrides enables after current access
// - Disable seen between halves of split operand
// - Disabled caches bypassed; maintenance still acts
// - Holding register serves loops in three words
// - Push writes a dirty selected line, then invalidates that line
// - Maintenance ignores enables and disable pin
// - Four modes; default nonserialized or write-through
// - Cachable read: hit served, miss fills
// - Write-through writes memory, no write allocate
// - Copyback write hit sets dirty, no bus
// - Dirty data leaves only on replace, inhibit, push
// - Dirty victim buffered, fill, then written back
// - Inhibited access bypasses, inhibit out during transfer
// - Inhibited hit pushes dirty or invalidates line
// - Serialized accesses strictly in order, read once
module ccp_cache_policy
  import ccp_pkg::*;
(
  // Clock and reset
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_b_i,
  // Control register move
  input  wire logic                    creg_wr_i,
  input  wire logic [31:0]             creg_wdata_i,
  output logic      [31:0]             creg_rdata_o,
  // External disable pin, active low
  input  wire logic                    cache_disable_input_b_i,
  // Instruction side
  input  wire logic                    ic_req_i,
  input  wire logic [31:1]             ic_addr_i,
  input  wire logic                    ic_cachable_i,
  input  wire logic                    ic_hit_i,
  input  wire logic [`CCP_WAYS-1:0]    ic_valid_i,
  output logic                         ic_fill_o,
  output logic      [`CCP_CTR_W-1:0]   ic_way_o,
  output logic                         ic_hold_hit_o,
  output logic                         ic_inval_o,
  // Data side request
  input  wire logic                    dc_req_i,
  input  wire logic                    dc_write_i,
  input  wire logic                    xlate_on_i,
  input  wire logic [1:0]              caching_mode_field_i,
  input  wire logic                    dc_hit_i,
  input  wire logic                    dc_hit_dirty_i,
  input  wire logic [`CCP_WAYS-1:0]    dc_valid_i,
  input  wire logic [`CCP_WAYS-1:0]    dc_dirty_i,
  output logic                         dc_ack_o,
  output logic                         busy_o,
  // Data array commands
  output logic      [`CCP_CTR_W-1:0]   dc_way_o,
  output logic                         dc_fill_o,
  output logic                         dc_update_o,
  output logic                         dc_set_dirty_o,
  output logic                         dc_inval_o,
  output logic                         dc_to_cbbuf_o,
  // Maintenance, one selected line per request
  input  wire logic                    maint_req_i,
  input  wire logic                    push_invalidate_op_i,
  input  wire logic                    maint_dc_i,
  input  wire logic                    maint_ic_i,
  input  wire logic                    maint_line_dirty_i,
  // Bus controller
  output logic                         bus_req_o,
  output logic                         bus_write_o,
  output logic                         bus_line_o,
  output logic                         cache_inhibit_out_o,
  output logic                         serialize_o,
  input  wire logic                    bus_done_i
);

  // Control register
  logic dce_q, dce_d, ice_q, ice_d;
  logic [31:0] creg_rdata_q, creg_rdata_d;
  always_comb begin
    dce_d = dce_q;
    ice_d = ice_q;
    if (creg_wr_i) begin
      dce_d = creg_wdata_i[`CCP_CREG_DCE_BIT];
      ice_d = creg_wdata_i[`CCP_CREG_ICE_BIT];
    end
    creg_rdata_d = 32'h0000_0000;
    creg_rdata_d[`CCP_CREG_DCE_BIT] = dce_d;
    creg_rdata_d[`CCP_CREG_ICE_BIT] = ice_d;
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dce_q        <= 1'b0;
      ice_q        <= 1'b0;
      creg_rdata_q <= `CCP_CREG_RESET;
    end else begin
      dce_q        <= dce_d;
      ice_q        <= ice_d;
      creg_rdata_q <= creg_rdata_d;
    end
  end

  // Disable pin synchroniser
  logic cache_disable_input_s1_q, cache_disable_input_s2_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cache_disable_input_s1_q <= 1'b1;
      cache_disable_input_s2_q <= 1'b1;
    end else begin
      cache_disable_input_s1_q <= cache_disable_input_b_i;
      cache_disable_input_s2_q <= cache_disable_input_s1_q;
    end
  end

  // First invalid way, else the counter's way
  function automatic logic [`CCP_CTR_W-1:0] ccp_pick(input logic [`CCP_WAYS-1:0] vld,
                                                     input logic [`CCP_CTR_W-1:0] ctr);
    logic [`CCP_CTR_W-1:0] w;
    w = ctr;
    for (int i = `CCP_WAYS - 1; i >= 0; i--) begin
      if (!vld[i]) w = i[`CCP_CTR_W-1:0];
    end
    return w;
  endfunction : ccp_pick

  // Instruction side
  logic                  ic_en;
  logic [`CCP_CTR_W-1:0] ic_ctr_q, ic_ctr_d, ic_way_q, ic_way_d;
  logic                  ic_fill_q, ic_fill_d, ic_hold_hit_q, ic_hold_hit_d;
  logic                  ic_inval_q, ic_inval_d, hold_v_q, hold_v_d;
  logic [31:3]           hold_tag_q, hold_tag_d;
  // Data side
  ccp_state_t            st_q, st_d;
  ccp_mode_t             mode;
  logic                  dis_q, dis_d, dc_en;
  logic [`CCP_CTR_W-1:0] dc_ctr_q, dc_ctr_d, dc_way_q, dc_way_d;
  logic                  wr_pend_q, wr_pend_d, wb_pend_q, wb_pend_d, mnt_q, mnt_d, ser_q, ser_d;
  logic                  dc_fill_q, dc_fill_d, dc_upd_q, dc_upd_d, dc_dirty_q, dc_dirty_d;
  logic                  dc_inval_q, dc_inval_d, cbbuf_q, cbbuf_d, ack_q, ack_d, busy_q, busy_d;
  logic                  breq_q, breq_d, bwr_q, bwr_d, bline_q, bline_d, cio_q, cio_d;
  assign ic_en = ice_q & ~dis_q;
  assign dc_en = dce_q & ~dis_q;
  always_comb begin
    ic_ctr_d      = ic_ctr_q;
    ic_way_d      = ic_way_q;
    ic_fill_d     = 1'b0;
    ic_hold_hit_d = 1'b0;
    hold_v_d      = hold_v_q;
    hold_tag_d    = hold_tag_q;
    if (ic_req_i) begin
      if (ic_en) begin
        ic_ctr_d = ic_ctr_q + 2'h1;
        if (!ic_hit_i && ic_cachable_i) begin
          ic_fill_d = 1'b1;
          ic_way_d  = ccp_pick(ic_valid_i, ic_ctr_q);
        end
      end else begin
        // Loop caught only while it stays in the first six bytes
        ic_hold_hit_d = hold_v_q && hold_tag_q == ic_addr_i[31:3]
                        && ic_addr_i[2:1] != `CCP_HOLD_WORDS;
        hold_v_d      = 1'b1;
        hold_tag_d    = ic_addr_i[31:3];
      end
    end
    if (ic_inval_d) hold_v_d = 1'b0;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ic_ctr_q      <= `CCP_CTR_RESET;
      ic_way_q      <= `CCP_CTR_RESET;
      ic_fill_q     <= 1'b0;
      ic_hold_hit_q <= 1'b0;
      hold_v_q      <= 1'b0;
      hold_tag_q    <= '0;
    end else begin
      ic_ctr_q      <= ic_ctr_d;
      ic_way_q      <= ic_way_d;
      ic_fill_q     <= ic_fill_d;
      ic_hold_hit_q <= ic_hold_hit_d;
      hold_v_q      <= hold_v_d;
      hold_tag_q    <= hold_tag_d;
    end
  end

  // Effective caching mode
  assign mode = xlate_on_i ? ccp_mode_t'(caching_mode_field_i) : (dc_en ? CCP_MODE_WTHRU : CCP_MODE_NONSER);
  // One access at a time keeps serialized order and single reads
  always_comb begin
    st_d = st_q;          dis_d = dis_q;         dc_ctr_d = dc_ctr_q;   dc_way_d = dc_way_q;
    wr_pend_d = wr_pend_q; wb_pend_d = wb_pend_q; mnt_d = mnt_q;         ser_d = ser_q;
    dc_fill_d = 1'b0;     dc_upd_d = 1'b0;       dc_dirty_d = 1'b0;     dc_inval_d = 1'b0;
    cbbuf_d = 1'b0;       ack_d = 1'b0;          ic_inval_d = 1'b0;
    breq_d = breq_q;      bwr_d = bwr_q;         bline_d = bline_q;     cio_d = cio_q;
    unique case (st_q)
      CCP_ST_IDLE: begin
        dis_d = ~cache_disable_input_s2_q;
        if (maint_req_i) begin
          if (maint_dc_i && push_invalidate_op_i && maint_line_dirty_i) begin
            {breq_d, bwr_d, bline_d, mnt_d} = 4'hF;
            st_d = CCP_ST_PUSH;
          end else begin
            dc_inval_d = maint_dc_i;
            ic_inval_d = maint_ic_i;
            ack_d      = 1'b1;
          end
        end else if (dc_req_i) begin
          wr_pend_d = dc_write_i;
          wb_pend_d = 1'b0;
          mnt_d     = 1'b0;
          ser_d     = mode == CCP_MODE_SERIAL;
          if (!dc_en) begin
            {breq_d, bwr_d, bline_d} = {1'b1, dc_write_i, 1'b0};
            st_d = CCP_ST_BYPS;
          end else if (mode == CCP_MODE_NONSER || mode == CCP_MODE_SERIAL) begin
            if (dc_hit_i && dc_hit_dirty_i) begin
              {breq_d, bwr_d, bline_d} = 3'h7;
              st_d = CCP_ST_PUSH;
            end else begin
              dc_inval_d = dc_hit_i;
              {breq_d, bwr_d, bline_d, cio_d} = {1'b1, dc_write_i, 2'h1};
              st_d = CCP_ST_INHB;
            end
          end else if (dc_write_i && mode == CCP_MODE_WTHRU) begin
            dc_upd_d = dc_hit_i;
            {breq_d, bwr_d, bline_d} = 3'h6;
            st_d = CCP_ST_WTHR;
          end else begin
            dc_ctr_d = dc_ctr_q + 2'h1;
            if (dc_hit_i) begin
              dc_upd_d   = dc_write_i;
              dc_dirty_d = dc_write_i;
              ack_d      = 1'b1;
            end else begin
              dc_way_d  = ccp_pick(dc_valid_i, dc_ctr_q);
              wb_pend_d = &dc_valid_i && dc_dirty_i[dc_ctr_q];
              cbbuf_d   = &dc_valid_i && dc_dirty_i[dc_ctr_q];
              {breq_d, bwr_d, bline_d} = 3'h5;
              st_d = CCP_ST_FILL;
            end
          end
        end
      end
      CCP_ST_FILL: begin
        if (bus_done_i) begin
          dc_fill_d  = 1'b1;
          dc_upd_d   = wr_pend_q;
          dc_dirty_d = wr_pend_q;
          if (wb_pend_q) begin
            {breq_d, bwr_d, bline_d} = 3'h7;
            st_d = CCP_ST_WBCK;
          end else begin
            breq_d = 1'b0;
            ack_d  = 1'b1;
            st_d   = CCP_ST_IDLE;
          end
        end
      end
      CCP_ST_WTHR: begin
        if (bus_done_i) begin
          dc_ctr_d = dc_ctr_q + 2'h1;
          breq_d   = 1'b0;
          ack_d    = 1'b1;
          st_d     = CCP_ST_IDLE;
        end
      end
      CCP_ST_PUSH: begin
        if (bus_done_i) begin
          dc_inval_d = 1'b1;
          if (mnt_q) begin
            ic_inval_d = maint_ic_i;
            breq_d     = 1'b0;
            ack_d      = 1'b1;
            st_d       = CCP_ST_IDLE;
          end else begin
            {breq_d, bwr_d, bline_d, cio_d} = {1'b1, wr_pend_q, 2'h1};
            st_d = CCP_ST_INHB;
          end
        end
      end
      CCP_ST_WBCK, CCP_ST_INHB, CCP_ST_BYPS: begin
        if (bus_done_i) begin
          {breq_d, cio_d, ser_d} = 3'h0;
          ack_d = 1'b1;
          st_d  = CCP_ST_IDLE;
        end
      end
      default: begin
        {breq_d, cio_d, ser_d} = 3'h0;
        st_d = CCP_ST_IDLE;
      end
    endcase
    busy_d = st_d != CCP_ST_IDLE;
  end
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= CCP_ST_IDLE;  dis_q <= 1'b0;      dc_ctr_q <= `CCP_CTR_RESET; dc_way_q <= `CCP_CTR_RESET;
      wr_pend_q <= 1'b0;    wb_pend_q <= 1'b0;  mnt_q <= 1'b0;              ser_q <= 1'b0;
      dc_fill_q <= 1'b0;    dc_upd_q <= 1'b0;   dc_dirty_q <= 1'b0;         dc_inval_q <= 1'b0;
      cbbuf_q <= 1'b0;      ack_q <= 1'b0;      ic_inval_q <= 1'b0;         busy_q <= 1'b0;
      breq_q <= 1'b0;       bwr_q <= 1'b0;      bline_q <= 1'b0;            cio_q <= 1'b0;
    end else begin
      st_q <= st_d;         dis_q <= dis_d;     dc_ctr_q <= dc_ctr_d;       dc_way_q <= dc_way_d;
      wr_pend_q <= wr_pend_d; wb_pend_q <= wb_pend_d; mnt_q <= mnt_d;       ser_q <= ser_d;
      dc_fill_q <= dc_fill_d; dc_upd_q <= dc_upd_d; dc_dirty_q <= dc_dirty_d; dc_inval_q <= dc_inval_d;
      cbbuf_q <= cbbuf_d;   ack_q <= ack_d;     ic_inval_q <= ic_inval_d;   busy_q <= busy_d;
      breq_q <= breq_d;     bwr_q <= bwr_d;     bline_q <= bline_d;         cio_q <= cio_d;
    end
  end
  assign creg_rdata_o        = creg_rdata_q;
  assign ic_fill_o           = ic_fill_q;
  assign ic_way_o            = ic_way_q;
  assign ic_hold_hit_o       = ic_hold_hit_q;
  assign ic_inval_o          = ic_inval_q;
  assign dc_ack_o            = ack_q;
  assign busy_o              = busy_q;
  assign dc_way_o            = dc_way_q;
  assign dc_fill_o           = dc_fill_q;
  assign dc_update_o         = dc_upd_q;
  assign dc_set_dirty_o      = dc_dirty_q;
  assign dc_inval_o          = dc_inval_q;
  assign dc_to_cbbuf_o       = cbbuf_q;
  assign bus_req_o           = breq_q;
  assign bus_write_o         = bwr_q;
  assign bus_line_o          = bline_q;
  assign cache_inhibit_out_o = cio_q;
  assign serialize_o         = ser_q;
endmodule : ccp_cache_policy

/* dv/ccp_bus_model.sv */
`timescale 1ns/100ps
module ccp_bus_model (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  // Transfer handshake
  input  wire logic       bus_req_i,
  input  wire logic [3:0] lat_i,
  output logic            bus_done_o
);
  // Wait cycles come from the bench so one model serves prompt and slow replies
  logic [3:0] cnt_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q      <= 4'h0;
      bus_done_o <= 1'b0;
    end else if (bus_done_o || !bus_req_i) begin
      cnt_q      <= 4'h0;
      bus_done_o <= 1'b0;
    end else if (cnt_q >= lat_i) begin
      bus_done_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule : ccp_bus_model

/* dv/ccp_cache_policy_properties.sv */
`timescale 1ns/100ps
module ccp_cache_policy_properties (
  // Clock, reset, register
  input wire logic        ref_clk_i,
  input wire logic        rst_b_i,
  input wire logic        creg_wr_i,
  input wire logic [31:0] creg_wdata_i,
  input wire logic [31:0] creg_rdata_o,
  input wire logic        cache_disable_input_b_i,
  // Data request
  input wire logic        dc_req_i,
  input wire logic        dc_write_i,
  input wire logic        xlate_on_i,
  input wire logic [1:0]  caching_mode_field_i,
  input wire logic        dc_hit_i,
  input wire logic        dc_hit_dirty_i,
  input wire logic        busy_o,
  input wire logic        dc_ack_o,
  input wire logic        dc_fill_o,
  input wire logic        dc_update_o,
  input wire logic        dc_set_dirty_o,
  input wire logic        dc_inval_o,
  // Maintenance and bus
  input wire logic        maint_req_i,
  input wire logic        push_invalidate_op_i,
  input wire logic        maint_dc_i,
  input wire logic        maint_line_dirty_i,
  input wire logic        bus_req_o,
  input wire logic        bus_write_o,
  input wire logic        bus_line_o,
  input wire logic        cache_inhibit_out_o
);
  // Pin history covers the synchroniser lag before the data cache counts as enabled
  logic [3:0] pin_q;
  logic       take;
  logic       en;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_q <= 4'hF;
    end else begin
      pin_q <= {pin_q[2:0], cache_disable_input_b_i};
    end
  end
  assign take = dc_req_i && !busy_o && !maint_req_i && xlate_on_i;
  assign en   = creg_rdata_o[31] && (&pin_q) && cache_disable_input_b_i;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_creg_map;
    creg_wr_i |=> creg_rdata_o == ($past(creg_wdata_i) & 32'h8000_8000);
  endproperty
  a_creg_map: assert property (p_creg_map) else $error("control register value wrong");
  property p_cio_bus;
    cache_inhibit_out_o |-> bus_req_o;
  endproperty
  a_cio_bus: assert property (p_cio_bus) else $error("inhibit out outside transfer");
  property p_inh_take;
    take && en && caching_mode_field_i[1] && !dc_hit_dirty_i |=> bus_req_o && cache_inhibit_out_o;
  endproperty
  a_inh_take: assert property (p_inh_take) else $error("inhibited access not bypassed");
  property p_wt_write;
    take && en && caching_mode_field_i == 2'h0 && dc_write_i |=> bus_req_o && bus_write_o && !dc_fill_o;
  endproperty
  a_wt_write: assert property (p_wt_write) else $error("write-through write wrong");
  property p_cb_hit;
    take && en && caching_mode_field_i == 2'h1 && dc_write_i && dc_hit_i |=> dc_set_dirty_o && dc_ack_o && !bus_req_o;
  endproperty
  a_cb_hit: assert property (p_cb_hit) else $error("copyback write hit wrong");
  property p_bypass;
    take && !creg_rdata_o[31] && dc_write_i |=> bus_req_o && !dc_update_o && !dc_set_dirty_o;
  endproperty
  a_bypass: assert property (p_bypass) else $error("disabled cache touched");
  property p_inval;
    maint_req_i && !busy_o && !push_invalidate_op_i && maint_dc_i |=> dc_inval_o && dc_ack_o;
  endproperty
  a_inval: assert property (p_inval) else $error("invalidate not done");
  property p_push;
    maint_req_i && !busy_o && push_invalidate_op_i && maint_dc_i && maint_line_dirty_i
      |=> (bus_req_o && bus_line_o && bus_write_o && !dc_inval_o) ##[1:40] dc_inval_o;
  endproperty
  a_push: assert property (p_push) else $error("push order wrong");
endmodule : ccp_cache_policy_properties
bind ccp_cache_policy ccp_cache_policy_properties ccp_cache_policy_properties_i (.*);

/* dv/ccp_cache_policy_tb.sv */
`timescale 1ns/100ps
module ccp_cache_policy_tb;
  import ccp_pkg::*;
  logic        ref_clk_i = 1'b0, rst_b_i = 1'b0, creg_wr_i = 1'b0, cache_disable_input_b_i = 1'b1;
  logic [31:0] creg_wdata_i = 32'h0, creg_rdata_o;
  logic        ic_req_i = 1'b0, ic_cachable_i = 1'b1, ic_hit_i = 1'b0;
  logic [31:1] ic_addr_i = 31'h0;
  logic [3:0]  ic_valid_i = 4'hF, dc_valid_i = 4'hF, dc_dirty_i = 4'h0, lat = 4'h0;
  logic        dc_req_i = 1'b0, dc_write_i = 1'b0, xlate_on_i = 1'b1, dc_hit_i = 1'b0, dc_hit_dirty_i = 1'b0;
  logic [1:0]  caching_mode_field_i = 2'h0, ic_way_o, dc_way_o;
  logic        maint_req_i = 1'b0, push_invalidate_op_i = 1'b0, maint_dc_i = 1'b0, maint_ic_i = 1'b0;
  logic        maint_line_dirty_i = 1'b0, bus_done_i, ic_fill_o, ic_hold_hit_o, ic_inval_o, dc_ack_o, busy_o;
  logic        dc_fill_o, dc_update_o, dc_set_dirty_o, dc_inval_o, dc_to_cbbuf_o;
  logic        bus_req_o, bus_write_o, bus_line_o, cache_inhibit_out_o, serialize_o;
  logic [10:0] fl;
  int          n_mismatch = 0, n_compared = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  ccp_cache_policy ccp_cache_policy_i (.*);
  ccp_bus_model ccp_bus_model_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .bus_req_i(bus_req_o),
                                 .lat_i(lat), .bus_done_o(bus_done_i));
  task finish_test;
    $display("mismatches %0d, compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task tick;
    @(posedge ref_clk_i);
    #1;
  endtask : tick
  task creg(input logic [31:0] d);
    {creg_wr_i, creg_wdata_i} = {1'b1, d};
    tick;
    creg_wr_i = 1'b0;
    tick;
  endtask : creg
  task pin(input logic b);
    cache_disable_input_b_i = b;
    repeat (4) tick;
  endtask : pin
  task ic(input logic [31:1] a, input logic h, input logic [3:0] v, input logic [3:0] e);
    {ic_addr_i, ic_hit_i, ic_valid_i} = {a, h, v};
    ic_req_i = 1'b1;
    tick;
    ic_req_i = 1'b0;
    check({ic_hold_hit_o, ic_fill_o, ic_way_o}, e);
    tick;
  endtask : ic
  // Gathers every command pulse of one operation; bus levels only count inside a transfer
  task go(input logic m);
    int i;
    fl = 11'h000;
    if (m) maint_req_i = 1'b1;
    else dc_req_i = 1'b1;
    tick;
    {dc_req_i, maint_req_i} = 2'b00;
    for (i = 0; i < 80; i++) begin
      fl = fl | {ic_inval_o, dc_fill_o, dc_to_cbbuf_o, dc_inval_o, dc_set_dirty_o, dc_update_o,
                 {serialize_o, cache_inhibit_out_o, bus_line_o, bus_write_o, bus_req_o} & {5{bus_req_o}}};
      if (dc_ack_o === 1'b1) begin
        check(busy_o, 1'b0);
        break;
      end
      tick;
    end
    if (i == 80) begin
      n_mismatch++;
      $display("wrong value at %0t: no acknowledge", $time);
      finish_test;
    end
    tick;
  endtask : go
  task dc(input logic [5:0] k);
    {dc_write_i, xlate_on_i, caching_mode_field_i, dc_hit_i, dc_hit_dirty_i} = k;
    go(1'b0);
  endtask : dc
  task mt(input logic [3:0] k);
    {push_invalidate_op_i, maint_dc_i, maint_ic_i, maint_line_dirty_i} = k;
    go(1'b1);
  endtask : mt
  task t_reg;
    check(creg_rdata_o, 32'h0000_0000);
    creg(32'hFFFF_FFFF);
    check(creg_rdata_o, 32'h8000_8000);
    creg(32'h0000_8000);
    check(creg_rdata_o, 32'h0000_8000);
  endtask : t_reg
  task t_ic;
    ic(31'h0, 1'b0, 4'hF, 4'h4);
    ic(31'h0, 1'b1, 4'hF, 4'h0);
    ic(31'h0, 1'b0, 4'hF, 4'h6);
    ic(31'h0, 1'b0, 4'hF, 4'h7);
    ic(31'h0, 1'b0, 4'hF, 4'h4);
    ic(31'h0, 1'b0, 4'hD, 4'h5);
    ic_cachable_i = 1'b0;
    ic(31'h0, 1'b0, 4'hF, 4'h1);
    ic_cachable_i = 1'b1;
    creg(32'h0000_0000);
    ic(31'h80, 1'b0, 4'hF, 4'h1);
    ic(31'h82, 1'b0, 4'hF, 4'h9);
    ic(31'h83, 1'b0, 4'hF, 4'h1);
    ic(31'h84, 1'b0, 4'hF, 4'h1);
    ic(31'h85, 1'b0, 4'hF, 4'h9);
  endtask : t_ic
  task t_dc;
    creg(32'h8000_0000);
    dc(6'b1_1_01_1_0);
    check(fl, 11'h060);
    dc(6'b1_1_00_0_0);
    check(fl, 11'h003);
    {lat, dc_dirty_i} = {4'h5, 4'h4};
    dc(6'b0_1_01_0_0);
    check(fl, 11'h307);
    check(dc_way_o, 32'h2);
    {lat, dc_dirty_i, dc_valid_i} = {4'h0, 4'h0, 4'hD};
    dc(6'b0_1_00_0_0);
    check(fl, 11'h205);
    check(dc_way_o, 32'h1);
    dc_valid_i = 4'hF;
  endtask : t_dc
  task t_inh;
    dc(6'b0_1_10_1_0);
    check(fl, 11'h089);
    dc(6'b0_1_11_1_1);
    check(fl[4:0], 5'h1F);
    dc(6'b1_0_10_0_0);
    check(fl, 11'h003);
  endtask : t_inh
  task t_dis;
    creg(32'h0000_0000);
    dc(6'b1_1_01_1_0);
    check(fl, 11'h003);
    creg(32'h8000_0000);
    pin(1'b0);
    dc(6'b1_1_01_1_0);
    check(fl, 11'h003);
    pin(1'b1);
    dc(6'b1_1_01_1_0);
    check(fl, 11'h060);
  endtask : t_dis
  task t_mnt;
    creg(32'h0000_0000);
    pin(1'b0);
    lat = 4'h2;
    mt(4'b1101);
    check(fl, 11'h087);
    mt(4'b0110);
    check(fl, 11'h480);
    pin(1'b1);
  endtask : t_mnt
  // Reset in mid-run clears the control register and the instruction counter
  task t_rst;
    creg(32'h8000_8000);
    rst_b_i = 1'b0;
    tick;
    rst_b_i = 1'b1;
    check(creg_rdata_o, 32'h0000_0000);
    creg(32'h0000_8000);
    ic(31'h0, 1'b0, 4'hF, 4'h4);
  endtask : t_rst
  initial begin
    repeat (3) @(posedge ref_clk_i);
    #1;
    rst_b_i = 1'b1;
    t_reg;
    t_ic;
    t_dc;
    t_inh;
    t_dis;
    t_mnt;
    t_rst;
    finish_test;
  end
endmodule : ccp_cache_policy_tb
